// file: rtl/rtctr_defs.svh
// register offsets, field positions, reset values and busy window lengths in ns for the rtc control block
`ifndef RTCTR_DEFS_SVH
`define RTCTR_DEFS_SVH
`define RTCTR_OFS_RUN_CTRL   12'h000
`define RTCTR_OFS_IRQ        12'h004
`define RTCTR_OFS_DIVIDER    12'h008
`define RTCTR_OFS_SECONDS    12'h00C
`define RTCTR_OFS_MINUTES    12'h010
`define RTCTR_OFS_HOURS      12'h014
`define RTCTR_OFS_DAYS       12'h018
`define RTCTR_OFS_TEST_MODE  12'h02C
`define RTCTR_OFS_PRESCALER  12'h030
`define RTCTR_OFS_TEST_PULSE 12'h034
`define RTCTR_BIT_RUN        0
`define RTCTR_BIT_CLEAR      1
`define RTCTR_BIT_PIF        1
`define RTCTR_BIT_AIF        0
`define RTCTR_BIT_BUSY       7
`define RTCTR_TEST_RST       4'h0
`define RTCTR_IRQSRC_RST     3'h7
`define RTCTR_WIN_244_NS     244000
`define RTCTR_WIN_122_NS     122000
`define RTCTR_WIN_61_NS      61000
`endif

// file: rtl/rtctr_pkg.sv
// types shared by the rtc control block
package rtctr_pkg;
	typedef struct packed {
		logic        run;
		logic        clear;
		logic [3:0]  test_sel;
	} rtctr_ctrl_t;
	typedef enum logic [1:0] {
		RTCTR_WIN_LONG,
		RTCTR_WIN_MID,
		RTCTR_WIN_SHORT,
		RTCTR_WIN_RSV
	} rtctr_win_t;
endpackage

// file: rtl/rtctr_sync.sv
// two-flop level synchroniser into the domain of its clk input (the bus clock in rtctr_top)
`timescale 1ns/1ps
module rtctr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// file: rtl/rtctr_top.sv
// rtc run/stop, test-mode and prescaler control with apb register slave
`timescale 1ns/1ps
`include "rtctr_defs.svh"
// What this block does
// - test selector decodes write, clock, bypass modes
// - test clock mode steps on pulse writes
// - carry bypass clocks each stage directly
// - system reset clears entry bit and record
// - test entry needs one then zero written
// - prescaler reads seven bits, bit7 zero
// - system reset leaves prescaler untouched
// - prescaler writes only in divider-write mode
// - in test clock mode any test pulse write makes one pulse
// - run bit reads one while synchronising
// - clear with stop zeroes prescaler, dividers
// - while running, no prescaler clearing
// - counting starts after start crosses domains
// - stopped counters hold their values
// - counter writes apply at once when idle
// - system reset clears run, clear, test selector, entry state and flags, sets source to 7; window code kept
// - power-on initialises run, clear, test selector, entry and interrupt state, not window code or timekeeping
// - busy window length from two-bit code
// - run bit starts, stops, reads busy
// - clear bit write-only, reads zero
// - flags read pending, clear on one
module rtctr_top #(
	parameter int CLK_HZ = 25000000
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clk32k,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             rtc_irq
);
	import rtctr_pkg::*;
	localparam int WIN_244 = (`RTCTR_WIN_244_NS / 1000) * (CLK_HZ / 1000000);
	localparam int WIN_122 = (`RTCTR_WIN_122_NS / 1000) * (CLK_HZ / 1000000);
	localparam int WIN_61  = (`RTCTR_WIN_61_NS / 1000) * (CLK_HZ / 1000000);

	rtctr_ctrl_t ctrl_reg;
	logic        run_sync;
	logic        ck_meta_reg;
	logic        ck_s_reg;
	logic        ck_d_reg;
	logic        tick;
	logic        wr;
	logic        entry_last_reg;
	logic        entry_bit_reg;
	logic        test_act_reg;
	logic [6:0]  presc_reg;
	logic [7:0]  div_reg;
	logic [5:0]  sec_reg;
	logic [5:0]  min_reg;
	logic [4:0]  hour_reg;
	logic [15:0] day_reg;
	logic [1:0]  win_reg;
	logic [13:0] busy_cnt_reg;
	logic [2:0]  isrc_reg;
	logic        pif_reg;
	logic        aif_reg;
	logic        step;
	logic        c_presc;
	logic        c_div;
	logic        c_sec;
	logic        c_min;
	logic        c_hour;
	logic        busy;
	logic        periodic_ev;
	logic [3:0]  tsel;

	assign wr      = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign tsel    = test_act_reg ? ctrl_reg.test_sel : `RTCTR_TEST_RST;

	rtctr_sync #(.W(1)) u_run_sync (
		.clk (clk),
		.rst (rst),
		.d   (ctrl_reg.run),
		.q   (run_sync)
	);

	// 32 kHz input sampled as a pin; the edge is taken from the second and third flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_meta_reg <= 1'b0;
			ck_s_reg    <= 1'b0;
			ck_d_reg    <= 1'b0;
		end else begin
			ck_meta_reg <= clk32k;
			ck_s_reg    <= ck_meta_reg;
			ck_d_reg    <= ck_s_reg;
		end
	end
	assign tick = ck_s_reg && !ck_d_reg;

	// run/stop and test selector writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg.run      <= 1'b0;
			ctrl_reg.clear    <= 1'b0;
			ctrl_reg.test_sel <= `RTCTR_TEST_RST;
		end else begin
			ctrl_reg.clear <= 1'b0;
			if (wr && paddr == `RTCTR_OFS_RUN_CTRL) begin
				ctrl_reg.run   <= pwdata[`RTCTR_BIT_RUN];
				ctrl_reg.clear <= pwdata[`RTCTR_BIT_CLEAR] && !pwdata[`RTCTR_BIT_RUN];
			end
			if (wr && paddr == `RTCTR_OFS_TEST_MODE)
				ctrl_reg.test_sel <= pwdata[4:1];
		end
	end

	// test entry sequence: a one then a zero written enters test mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			entry_bit_reg  <= 1'b0;
			entry_last_reg <= 1'b0;
			test_act_reg   <= 1'b0;
		end else if (wr && paddr == `RTCTR_OFS_TEST_MODE) begin
			entry_bit_reg  <= pwdata[0];
			entry_last_reg <= pwdata[0];
			if (entry_last_reg && !pwdata[0])
				test_act_reg <= 1'b1;
		end
	end

	// a test pulse write replaces the 32 kHz edge
	always_comb begin
		if (tsel[1:0] == 2'b10)
			step = wr && paddr == `RTCTR_OFS_TEST_PULSE;
		else
			step = tick;
	end

	assign c_presc = (presc_reg == 7'h7F) || tsel[3];
	assign c_div   = (div_reg == 8'hFF) || tsel[3];
	assign c_sec   = (sec_reg == 6'd59) || tsel[2];
	assign c_min   = (min_reg == 6'd59) || tsel[2];
	assign c_hour  = (hour_reg == 5'd23) || tsel[2];

	// timekeeping is never reset: a system reset must not disturb it
	always_ff @(posedge clk) begin
		if (ctrl_reg.clear && !run_sync) begin
			presc_reg <= '0;
			div_reg   <= '0;
		end else if (wr && paddr == `RTCTR_OFS_PRESCALER && tsel == `RTCTR_TEST_RST) begin
			presc_reg <= pwdata[6:0];
		end else if (wr && paddr == `RTCTR_OFS_DIVIDER && tsel == `RTCTR_TEST_RST) begin
			div_reg <= pwdata[7:0];
		end else if (run_sync && step) begin
			presc_reg <= presc_reg + 7'h01;
			if (c_presc)
				div_reg <= div_reg + 8'h01;
		end
	end

	// counter writes land immediately when not busy
	always_ff @(posedge clk) begin
		if (wr && !busy && paddr == `RTCTR_OFS_SECONDS)
			sec_reg <= (pwdata[5:0] > 6'd59) ? 6'h00 : pwdata[5:0];
		else if (run_sync && step && c_presc && c_div)
			sec_reg <= c_sec ? 6'h00 : sec_reg + 6'h01;
		if (wr && !busy && paddr == `RTCTR_OFS_MINUTES)
			min_reg <= (pwdata[5:0] > 6'd59) ? 6'h00 : pwdata[5:0];
		else if (run_sync && step && c_presc && c_div && c_sec)
			min_reg <= c_min ? 6'h00 : min_reg + 6'h01;
		if (wr && !busy && paddr == `RTCTR_OFS_HOURS)
			hour_reg <= (pwdata[4:0] > 5'd23) ? 5'h00 : pwdata[4:0];
		else if (run_sync && step && c_presc && c_div && c_sec && c_min)
			hour_reg <= c_hour ? 5'h00 : hour_reg + 5'h01;
		if (wr && !busy && paddr == `RTCTR_OFS_DAYS)
			day_reg <= pwdata[15:0];
		else if (run_sync && step && c_presc && c_div && c_sec && c_min && c_hour)
			day_reg <= day_reg + 16'h0001;
		if (wr && paddr == `RTCTR_OFS_RUN_CTRL)
			win_reg <= pwdata[6:5];
	end

	// busy window once per second, length per code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_cnt_reg <= '0;
		end else if (run_sync && step && c_presc && c_div) begin
			case (rtctr_win_t'(win_reg))
				RTCTR_WIN_LONG:  busy_cnt_reg <= 14'(WIN_244);
				RTCTR_WIN_MID:   busy_cnt_reg <= 14'(WIN_122);
				RTCTR_WIN_SHORT: busy_cnt_reg <= 14'(WIN_61);
				default:         busy_cnt_reg <= 14'(WIN_61);
			endcase
		end else if (busy_cnt_reg != '0) begin
			busy_cnt_reg <= busy_cnt_reg - 14'h0001;
		end
	end
	assign busy = busy_cnt_reg != '0;

	assign periodic_ev = run_sync && step && c_presc && c_div && isrc_reg == 3'h3;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			isrc_reg <= `RTCTR_IRQSRC_RST;
			pif_reg  <= 1'b0;
			aif_reg  <= 1'b0;
		end else begin
			if (wr && paddr == `RTCTR_OFS_IRQ)
				isrc_reg <= pwdata[7:5];
			if (periodic_ev)
				pif_reg <= 1'b1;
			else if (wr && paddr == `RTCTR_OFS_IRQ && pwdata[`RTCTR_BIT_PIF])
				pif_reg <= 1'b0;
			if (wr && paddr == `RTCTR_OFS_IRQ && pwdata[`RTCTR_BIT_AIF])
				aif_reg <= 1'b0;
		end
	end
	assign rtc_irq = pif_reg || aif_reg;

	// read mux
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`RTCTR_OFS_RUN_CTRL:
					prdata <= {24'h0, busy, win_reg, 4'h0, ctrl_reg.run != run_sync};
				`RTCTR_OFS_IRQ:       prdata <= {24'h0, isrc_reg, 3'h0, pif_reg, aif_reg};
				`RTCTR_OFS_DIVIDER:   prdata <= {24'h0, div_reg};
				`RTCTR_OFS_SECONDS:   prdata <= {26'h0, sec_reg};
				`RTCTR_OFS_MINUTES:   prdata <= {26'h0, min_reg};
				`RTCTR_OFS_HOURS:     prdata <= {27'h0, hour_reg};
				`RTCTR_OFS_DAYS:      prdata <= {16'h0, day_reg};
				`RTCTR_OFS_TEST_MODE: prdata <= {27'h0, ctrl_reg.test_sel, entry_bit_reg};
				`RTCTR_OFS_PRESCALER: prdata <= {25'h0, presc_reg};
				default:              prdata <= '0;
			endcase
		end
	end

	property p_clear_zero;
		@(posedge clk) disable iff (rst)
		(ctrl_reg.clear && !run_sync) |=> presc_reg == 7'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("prescaler not cleared");
	property p_run_busy;
		@(posedge clk) disable iff (rst)
		$rose(ctrl_reg.run) && !run_sync |=> ctrl_reg.run != run_sync;
	endproperty
	a_run_busy: assert property (p_run_busy)
		else $error("busy not shown");
	property p_sync_lat;
		@(posedge clk) disable iff (rst)
		$changed(ctrl_reg.run) |-> ##2 run_sync == $past(ctrl_reg.run, 2);
	endproperty
	a_sync_lat: assert property (p_sync_lat)
		else $error("sync latency wrong");
	property p_hold;
		@(posedge clk) disable iff (rst)
		!run_sync && !wr |=> $stable(sec_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("seconds moved while stopped");
	property p_pulse;
		@(posedge clk) disable iff (rst)
		tsel == 4'h2 && run_sync && wr && paddr == `RTCTR_OFS_TEST_PULSE
		|=> presc_reg == $past(presc_reg) + 7'h01;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("pulse lost");
	property p_presc_wr;
		@(posedge clk) disable iff (rst)
		wr && paddr == `RTCTR_OFS_PRESCALER && tsel != 4'h0 && !run_sync
		&& !ctrl_reg.clear |=> $stable(presc_reg);
	endproperty
	a_presc_wr: assert property (p_presc_wr)
		else $error("prescaler write accepted");
	property p_flag_set;
		@(posedge clk) disable iff (rst)
		periodic_ev |=> pif_reg;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag set lost");
	property p_entry;
		@(posedge clk) disable iff (rst)
		!test_act_reg && !(entry_last_reg && wr && paddr == `RTCTR_OFS_TEST_MODE)
		|=> !test_act_reg;
	endproperty
	a_entry: assert property (p_entry)
		else $error("test mode entered early");
	property p_rd_clear_bit;
		@(posedge clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `RTCTR_OFS_RUN_CTRL |=> !prdata[1];
	endproperty
	a_rd_clear_bit: assert property (p_rd_clear_bit)
		else $error("clear bit read back set");
	property p_rd_idle;
		@(posedge clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `RTCTR_OFS_RUN_CTRL
		&& ctrl_reg.run == run_sync |=> !prdata[0];
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("run bit busy while settled");
	property p_rd_presc_msb;
		@(posedge clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == `RTCTR_OFS_PRESCALER |=> !prdata[7];
	endproperty
	a_rd_presc_msb: assert property (p_rd_presc_msb)
		else $error("prescaler reserved bit set");
	property p_reset_entry;
		@(posedge clk)
		$fell(rst) |-> !entry_bit_reg && !entry_last_reg && !test_act_reg;
	endproperty
	a_reset_entry: assert property (p_reset_entry)
		else $error("entry state survived reset");
	property p_reset_irq;
		@(posedge clk)
		$fell(rst) |-> isrc_reg == `RTCTR_IRQSRC_RST && !pif_reg && !aif_reg;
	endproperty
	a_reset_irq: assert property (p_reset_irq)
		else $error("interrupt state survived reset");
	property p_pif_clear;
		@(posedge clk) disable iff (rst)
		wr && paddr == `RTCTR_OFS_IRQ && pwdata[`RTCTR_BIT_PIF] && !periodic_ev
		|=> !pif_reg;
	endproperty
	a_pif_clear: assert property (p_pif_clear)
		else $error("flag not cleared");
	property p_presc_accept;
		@(posedge clk) disable iff (rst)
		wr && paddr == `RTCTR_OFS_PRESCALER && tsel == 4'h0
		&& !(ctrl_reg.clear && !run_sync) |=> presc_reg == $past(pwdata[6:0]);
	endproperty
	a_presc_accept: assert property (p_presc_accept)
		else $error("prescaler write lost");
	property p_sec_write;
		@(posedge clk) disable iff (rst)
		wr && !busy && paddr == `RTCTR_OFS_SECONDS && pwdata[5:0] <= 6'd59
		|=> sec_reg == $past(pwdata[5:0]);
	endproperty
	a_sec_write: assert property (p_sec_write)
		else $error("seconds write lost");
endmodule

// file: verif/tb_top.sv
// self-checking bench for the rtc run/stop, test-mode and prescaler control block
`timescale 1ns/1ps
`include "rtctr_defs.svh"
module tb_top;
	logic        clk;
	logic        rst;
	logic        clk32k;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rtc_irq;
	logic [31:0] rd;
	int          n_errors;
	int          n_checks;
	int          cycles;

	rtctr_top uut (.clk(clk), .rst(rst), .clk32k(clk32k), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rtc_irq(rtc_irq));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// slow clock with a phase unrelated to the bus clock
	initial begin
		clk32k = 1'b0;
		#7000;
		forever #15259 clk32k = ~clk32k;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a lost handshake must not hang the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			print_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, rd & m, e);
	endtask

	// sync delay is two bus clock cycles; the wait is by reads, not cycles
	task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		for (int i = 0; i < 1000; i++) begin
			xfer(1'b0, a, 32'h0);
			if ((rd & m) === e)
				break;
		end
		chk(nm, rd & m, e);
	endtask

	task t_reset_vals;
		rchk(`RTCTR_OFS_RUN_CTRL, 32'h3, 32'h0, "run_ctrl");
		rchk(`RTCTR_OFS_IRQ, 32'hFF, 32'hE0, "irq_reg");
		rchk(`RTCTR_OFS_TEST_MODE, 32'h1F, 32'h0, "test_mode");
		rchk(12'h03C, 32'hFFFFFFFF, 32'h0, "unmapped");
		chk("rtc_irq", {31'h0, rtc_irq}, 32'h0);
		$display("test reset_vals done");
	endtask

	task t_sysreset;
		wr(`RTCTR_OFS_SECONDS, 32'h15);
		wr(`RTCTR_OFS_PRESCALER, 32'h33);
		wr(`RTCTR_OFS_TEST_MODE, 32'h03);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rchk(`RTCTR_OFS_SECONDS, 32'h3F, 32'h15, "seconds");
		rchk(`RTCTR_OFS_PRESCALER, 32'h7F, 32'h33, "prescaler");
		rchk(`RTCTR_OFS_TEST_MODE, 32'h1F, 32'h0, "test_mode");
		// a zero write right after reset must not complete the entry sequence
		wr(`RTCTR_OFS_TEST_MODE, 32'h04);
		wr(`RTCTR_OFS_PRESCALER, 32'h21);
		rchk(`RTCTR_OFS_PRESCALER, 32'h7F, 32'h21, "prescaler");
		$display("test sysreset done");
	endtask

	task t_test_mode;
		wr(`RTCTR_OFS_TEST_MODE, 32'h05);
		wr(`RTCTR_OFS_TEST_MODE, 32'h04);
		wr(`RTCTR_OFS_PRESCALER, 32'h55);
		rchk(`RTCTR_OFS_PRESCALER, 32'h7F, 32'h21, "prescaler");
		wr(`RTCTR_OFS_TEST_MODE, 32'h00);
		wr(`RTCTR_OFS_PRESCALER, 32'hFF);
		rchk(`RTCTR_OFS_PRESCALER, 32'hFF, 32'h7F, "prescaler");
		$display("test test_mode done");
	endtask

	task t_run_stop;
		wr(`RTCTR_OFS_RUN_CTRL, 32'h1);
		rchk(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h1, "run_busy");
		poll(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h0, "run_done");
		wr(`RTCTR_OFS_RUN_CTRL, 32'h0);
		rchk(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h1, "stop_busy");
		poll(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h0, "stop_done");
		$display("test run_stop done");
	endtask

	task t_pulse;
		logic [6:0] p;
		wr(`RTCTR_OFS_TEST_MODE, 32'h04);
		wr(`RTCTR_OFS_RUN_CTRL, 32'h1);
		poll(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h0, "run_done");
		xfer(1'b0, `RTCTR_OFS_PRESCALER, 32'h0);
		p = rd[6:0];
		wr(`RTCTR_OFS_TEST_PULSE, 32'hA5);
		rchk(`RTCTR_OFS_PRESCALER, 32'h7F, {25'h0, p + 7'h01}, "presc_pulse");
		wr(`RTCTR_OFS_RUN_CTRL, 32'h0);
		poll(`RTCTR_OFS_RUN_CTRL, 32'h1, 32'h0, "stop_done");
		wr(`RTCTR_OFS_TEST_MODE, 32'h00);
		$display("test pulse done");
	endtask

	task t_clear;
		wr(`RTCTR_OFS_IRQ, 32'hE3);
		wr(`RTCTR_OFS_RUN_CTRL, 32'h22);
		rchk(`RTCTR_OFS_RUN_CTRL, 32'h2, 32'h0, "clear_bit");
		rchk(`RTCTR_OFS_RUN_CTRL, 32'h60, 32'h20, "window");
		rchk(`RTCTR_OFS_IRQ, 32'h3, 32'h0, "flags");
		poll(`RTCTR_OFS_PRESCALER, 32'h7F, 32'h0, "prescaler");
		rchk(`RTCTR_OFS_DIVIDER, 32'hFF, 32'h0, "divider");
		$display("test clear done");
	endtask

	initial begin
		n_errors = 0;
		n_checks = 0;
		cycles   = 0;
		rst      = 1'b1;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset_vals();
		t_sysreset();
		t_test_mode();
		t_run_stop();
		t_pulse();
		t_clear();
		print_verdict();
	end
endmodule
